// ===== logic/csled_consts.vh
// Timing constants and colour codes for the camera status lamp driver
`ifndef CSLED_CONSTS_VH
`define CSLED_CONSTS_VH

// Lamp colour codes {green, red}; amber is both
`define CSLED_COL_OFF    2'h0
`define CSLED_COL_RED    2'h1
`define CSLED_COL_GREEN  2'h2
`define CSLED_COL_AMBER  2'h3

// Clock rate, tick length, blink half periods, detect minimum and trigger hold times
`define CSLED_CLK_HZ         100000000
`define CSLED_TICK_US        1000
`define CSLED_TICK_CYC       ((`CSLED_CLK_HZ / 1000000) * `CSLED_TICK_US)
`define CSLED_FAST_HALF_MS   125
`define CSLED_SLOW_HALF_MS   500
`define CSLED_TRIG_HALF_MS   100
`define CSLED_DETECT_MIN_MS  1000
`define CSLED_TRIG_HOLD_MS   500

`endif

// ===== logic/csled_driver.v
// Status lamp driver for the power/trigger and link indicators
`timescale 1ns/10ps
`default_nettype none
`include "csled_consts.vh"

module csled_driver
#(
  parameter integer TICK_CYC      = `CSLED_TICK_CYC,
  parameter integer FAST_HALF_MS  = `CSLED_FAST_HALF_MS,
  parameter integer SLOW_HALF_MS  = `CSLED_SLOW_HALF_MS,
  parameter integer TRIG_HALF_MS  = `CSLED_TRIG_HALF_MS,
  parameter integer DETECT_MIN_MS = `CSLED_DETECT_MIN_MS,
  parameter integer TRIG_HOLD_MS  = `CSLED_TRIG_HOLD_MS
)
(
  // Clock and reset
  input  wire       core_clk,
  input  wire       sys_rst,
  // Camera core status
  input  wire       init_done,
  input  wire       trigger_mode,
  input  wire       trigger_pulse,
  // Link layer status
  input  wire       link_powering,
  input  wire       link_cable_power,
  input  wire       link_detecting,
  input  wire       link_up,
  input  wire       link_waiting,
  input  wire       link_streaming,
  input  wire       link_testing,
  // Power/trigger indicator {green, red}
  output reg  [1:0] power_trigger_indicator,
  // Link indicator {green, red}
  output reg  [1:0] link_indicator
);

  localparam [5:0] ST_DARK   = 6'h01;
  localparam [5:0] ST_NOCONN = 6'h02;
  localparam [5:0] ST_DETECT = 6'h04;
  localparam [5:0] ST_UP     = 6'h08;
  localparam [5:0] ST_HOLD   = 6'h10;
  localparam [5:0] ST_POWER  = 6'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers (two flops, first flop feeds only the second)
  wire [9:0] in_raw;
  reg  [9:0] sync1_reg;
  reg  [9:0] sync2_reg;

  assign in_raw = {init_done, trigger_mode, trigger_pulse, link_powering,
                   link_cable_power, link_detecting, link_up, link_waiting,
                   link_streaming, link_testing};

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1)
    begin : g_sync
      always @(posedge core_clk)
      begin
        if (sys_rst)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end
        else
        begin
          sync1_reg[gi] <= in_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  wire s_init   = sync2_reg[9];
  wire s_tmode  = sync2_reg[8];
  wire s_trig   = sync2_reg[7];
  wire s_pwrup  = sync2_reg[6];
  wire s_cable  = sync2_reg[5];
  wire s_detect = sync2_reg[4];
  wire s_up     = sync2_reg[3];
  wire s_wait   = sync2_reg[2];
  wire s_stream = sync2_reg[1];
  wire s_test   = sync2_reg[0];

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and free-running blink phases
  reg  [23:0] tick_cnt_reg;
  reg         tick_reg;
  reg  [15:0] fast_cnt_reg;
  reg  [15:0] slow_cnt_reg;
  reg  [15:0] trig_cnt_reg;
  reg         fast_ph_reg;
  reg         slow_ph_reg;
  reg         trig_ph_reg;

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      tick_cnt_reg <= 24'h000000;
      tick_reg     <= 1'b0;
    end
    else if (tick_cnt_reg == TICK_CYC[23:0] - 24'h000001)
    begin
      tick_cnt_reg <= 24'h000000;
      tick_reg     <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 24'h000001;
      tick_reg     <= 1'b0;
    end
  end

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      fast_cnt_reg <= 16'h0000;
      slow_cnt_reg <= 16'h0000;
      trig_cnt_reg <= 16'h0000;
      fast_ph_reg  <= 1'b0;
      slow_ph_reg  <= 1'b0;
      trig_ph_reg  <= 1'b0;
    end
    else if (tick_reg)
    begin
      if (fast_cnt_reg == FAST_HALF_MS[15:0] - 16'h0001)
      begin
        fast_cnt_reg <= 16'h0000;
        fast_ph_reg  <= ~fast_ph_reg;
      end
      else
        fast_cnt_reg <= fast_cnt_reg + 16'h0001;
      if (slow_cnt_reg == SLOW_HALF_MS[15:0] - 16'h0001)
      begin
        slow_cnt_reg <= 16'h0000;
        slow_ph_reg  <= ~slow_ph_reg;
      end
      else
        slow_cnt_reg <= slow_cnt_reg + 16'h0001;
      // Own rate, never reset by trigger edges
      if (trig_cnt_reg == TRIG_HALF_MS[15:0] - 16'h0001)
      begin
        trig_cnt_reg <= 16'h0000;
        trig_ph_reg  <= ~trig_ph_reg;
      end
      else
        trig_cnt_reg <= trig_cnt_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger activity: retriggered hold window after each trigger edge
  reg         trig_d_reg;
  reg  [15:0] trig_hold_reg;
  wire        trig_edge = s_trig & ~trig_d_reg;
  wire        trig_active = s_tmode & (trig_hold_reg != 16'h0000);

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      trig_d_reg    <= 1'b0;
      trig_hold_reg <= 16'h0000;
    end
    else
    begin
      trig_d_reg <= s_trig;
      if (trig_edge)
        trig_hold_reg <= TRIG_HOLD_MS[15:0];
      else if (tick_reg && trig_hold_reg != 16'h0000)
        trig_hold_reg <= trig_hold_reg - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power/trigger indicator
  reg [1:0] pt_next;

  always @*
  begin
    if (!s_init)
      pt_next = `CSLED_COL_AMBER;
    else if (trigger_mode_on_blink(trig_active))
      pt_next = trig_ph_reg ? `CSLED_COL_GREEN : `CSLED_COL_OFF;
    else
      pt_next = `CSLED_COL_GREEN;
  end

  function trigger_mode_on_blink;
    input act;
    begin
      trigger_mode_on_blink = act;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link state machine with minimum detect display time
  reg  [5:0]  state_reg;
  reg  [5:0]  state_next;
  reg  [15:0] det_ms_reg;
  reg         det_cable_reg;
  wire        det_min_done = (det_ms_reg >= DETECT_MIN_MS[15:0]);

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_DARK, ST_NOCONN, ST_POWER, ST_UP:
      begin
        if (s_detect)
          state_next = ST_DETECT;
        else if (s_up)
          state_next = ST_UP;
        else if (s_pwrup)
          state_next = ST_POWER;
        else if (!s_cable && state_reg != ST_DARK)
          state_next = ST_NOCONN;
        else if (s_cable)
          state_next = ST_DARK;
        else
          state_next = ST_NOCONN;
      end
      ST_DETECT:
      begin
        if (!s_detect)
          state_next = ST_HOLD;
      end
      ST_HOLD:
      begin
        if (s_detect)
          state_next = ST_DETECT;
        else if (det_min_done)
          state_next = s_up ? ST_UP : (s_cable ? ST_DARK : ST_NOCONN);
      end
      default:
        state_next = ST_DARK;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_reg     <= ST_DARK;
      det_ms_reg    <= 16'h0000;
      det_cable_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg != ST_DETECT && state_reg != ST_HOLD)
      begin
        det_ms_reg    <= 16'h0000;
        det_cable_reg <= s_cable;
      end
      else if (tick_reg && !det_min_done)
        det_ms_reg <= det_ms_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link indicator pattern select
  reg [1:0] lk_next;

  always @*
  begin
    case (state_reg)
      ST_DARK:
        lk_next = `CSLED_COL_OFF;
      ST_POWER:
        lk_next = `CSLED_COL_AMBER;
      ST_NOCONN:
        lk_next = (slow_ph_reg && !s_cable) ? `CSLED_COL_RED : `CSLED_COL_OFF;
      ST_DETECT, ST_HOLD:
      begin
        if (det_cable_reg)
          lk_next = fast_ph_reg ? `CSLED_COL_GREEN : `CSLED_COL_AMBER;
        else
          lk_next = fast_ph_reg ? `CSLED_COL_AMBER : `CSLED_COL_OFF;
      end
      ST_UP:
      begin
        if (s_test)
          lk_next = slow_ph_reg ? `CSLED_COL_GREEN : `CSLED_COL_AMBER;
        else if (s_stream)
          lk_next = fast_ph_reg ? `CSLED_COL_GREEN : `CSLED_COL_OFF;
        else if (s_wait)
          lk_next = slow_ph_reg ? `CSLED_COL_AMBER : `CSLED_COL_OFF;
        else
          lk_next = `CSLED_COL_GREEN;
      end
      default:
        lk_next = `CSLED_COL_OFF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      power_trigger_indicator <= `CSLED_COL_AMBER;
      link_indicator          <= `CSLED_COL_OFF;
    end
    else
    begin
      power_trigger_indicator <= pt_next;
      link_indicator          <= lk_next;
    end
  end

endmodule
`default_nettype wire

// ===== verif/csled_lamp_obs.sv
// Operator view of one bicolour lamp: colours seen and changes
`timescale 1ns/10ps
`default_nettype none
module csled_lamp_obs
(
  // Clock and control
  input  wire logic       core_clk,
  input  wire logic       clear,
  // Lamp {green, red}
  input  wire logic [1:0] lamp,
  // Seen since clear
  output var  logic [3:0] seen,
  output var  logic [7:0] changes
);
  logic [1:0] last_reg;
  always @(posedge core_clk)
  begin
    last_reg <= lamp;
    seen     <= clear ? 4'h0 : seen | (4'h1 << lamp);
    changes  <= clear ? 8'h00 : changes + {7'h00, lamp !== last_reg};
  end
endmodule
`default_nettype wire

// ===== verif/csled_driver_asserts.sv
// Checker for the camera status lamp driver
`timescale 1ns/10ps
`default_nettype none
module csled_driver_asserts
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       sys_rst,
  // Status inputs
  input wire logic       init_done,
  input wire logic       trigger_mode,
  input wire logic       link_powering,
  input wire logic       link_cable_power,
  input wire logic       link_detecting,
  input wire logic       link_up,
  input wire logic       link_waiting,
  input wire logic       link_streaming,
  input wire logic       link_testing,
  // Lamps
  input wire logic [1:0] power_trigger_indicator,
  input wire logic [1:0] link_indicator
);
  // Detect hold long gone once the age saturates
  logic [5:0] det_age_reg;
  wire logic  det_old = det_age_reg == 6'h3f;
  wire logic  up_old  = link_up && det_old;
  always @(posedge core_clk)
    if (sys_rst || link_detecting)
      det_age_reg <= 6'h00;
    else if (!det_old)
      det_age_reg <= det_age_reg + 6'h01;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////
  sequence s_lamp_relit;
    power_trigger_indicator == 2'h0 ##1 power_trigger_indicator == 2'h2;
  endsequence
  sequence s_detect_blip;
    !link_detecting ##1 link_detecting ##1 !link_detecting [*8];
  endsequence
  a_init_amber: assert property (!init_done [*6] |-> power_trigger_indicator == 2'h3)
    else $error("power lamp not amber while initializing");
  a_run_green: assert property ((init_done && !trigger_mode) [*6] |->
    power_trigger_indicator == 2'h2)
    else $error("power lamp not green in operation");
  a_trig_colour: assert property (init_done [*6] |-> !power_trigger_indicator[0])
    else $error("power lamp colour wrong in operation");
  a_trig_rate: assert property (s_lamp_relit |-> (power_trigger_indicator != 2'h0) [*8])
    else $error("trigger blink half period too short");
  a_no_red_cable: assert property (link_cable_power [*6] |-> link_indicator != 2'h1)
    else $error("red link lamp on cable power");
  a_no_conn_dark: assert property ((!link_up && !link_powering && link_cable_power && det_old)
    [*6] |-> link_indicator == 2'h0)
    else $error("link lamp lit without link");
  a_detect_hold: assert property (s_detect_blip |-> (link_cable_power ? link_indicator[1] :
    link_indicator[0] == link_indicator[1]) [*8])
    else $error("detect pattern not held");
  a_idle_green: assert property ((up_old && !link_waiting && !link_streaming && !link_testing)
    [*6] |-> link_indicator == 2'h2)
    else $error("idle link lamp not green");
  a_wait_amber: assert property ((up_old && link_waiting && !link_streaming && !link_testing)
    [*6] |-> link_indicator[0] == link_indicator[1])
    else $error("waiting link lamp not amber or off");
  a_stream_green: assert property ((up_old && link_streaming && !link_testing) [*6] |->
    !link_indicator[0])
    else $error("streaming link lamp not green or off");
  a_test_alt: assert property ((up_old && link_testing) [*6] |-> link_indicator[1])
    else $error("test link lamp not green or amber");
endmodule
`default_nettype wire

// ===== verif/test_camera_status_led_driver.sv
// Testbench for the camera status lamp driver
`timescale 1ns/10ps
`default_nettype none
module test_camera_status_led_driver;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        init_done = 1'b0;
  logic        trigger_mode = 1'b0;
  logic        trigger_pulse = 1'b0;
  logic        link_detecting = 1'b0;
  logic        obs_clear = 1'b1;
  logic [5:0]  link_in = 6'h00;
  wire logic [1:0] ptr_lamp;
  wire logic [1:0] link_lamp;
  logic [3:0]  ptr_seen;
  logic [3:0]  link_seen;
  logic [7:0]  ptr_chg;
  logic [7:0]  link_chg;
  int          fail_count = 0;
  int          compares = 0;
  int          trig_period = 0;
  int          trig_cnt = 0;
  // Rows: {powering, cable, up, waiting, streaming, testing}, colours seen, rate
  logic [11:0] rows [0:8] = '{12'h820, 12'h00d, 12'h404, 12'h210, 12'h325,
                              12'h296, 12'h271, 12'h3f1, 12'h396};
  // Trigger hold keeps its full length so the end of trigger activity is seen
  csled_driver #(.TICK_CYC(4), .FAST_HALF_MS(2), .SLOW_HALF_MS(5), .TRIG_HALF_MS(3),
    .DETECT_MIN_MS(5)) dut (.core_clk, .sys_rst, .init_done,
    .trigger_mode, .trigger_pulse, .link_powering(link_in[5]), .link_cable_power(link_in[4]),
    .link_detecting, .link_up(link_in[3]), .link_waiting(link_in[2]),
    .link_streaming(link_in[1]), .link_testing(link_in[0]),
    .power_trigger_indicator(ptr_lamp), .link_indicator(link_lamp));
  csled_lamp_obs ptr_obs (.core_clk, .clear(obs_clear), .lamp(ptr_lamp), .seen(ptr_seen),
    .changes(ptr_chg));
  csled_lamp_obs link_obs (.core_clk, .clear(obs_clear), .lamp(link_lamp), .seen(link_seen),
    .changes(link_chg));
  initial
    forever #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    trig_cnt      <= (trig_cnt + 1 >= trig_period) ? 0 : trig_cnt + 1;
    trigger_pulse <= trig_period != 0 && trig_cnt == 0;
  end
  ////////////////////////////////////////////////
  function automatic logic [7:0] rate_of(input logic [7:0] n);
    return (n == 8'h00) ? 8'h00 : (n <= 8'h05) ? 8'h01 : 8'h02;
  endfunction
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic watch(input int n);
    obs_clear <= 1'b1;
    @(posedge core_clk);
    obs_clear <= 1'b0;
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (6000) @(posedge core_clk);
    fail_count++;
    report_and_stop();
  end
  ////////////////////////////////////////////////
  initial
  begin
    repeat (9) @(posedge core_clk);
    #1 check("reset power lamp", {6'h00, ptr_lamp}, 8'h03);
    check("reset link lamp", {6'h00, link_lamp}, 8'h00);
    @(posedge core_clk);
    sys_rst   <= 1'b0;
    init_done <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1 check("run power lamp", {6'h00, ptr_lamp}, 8'h02);
    for (int i = 0; i < 9; i++)
    begin
      @(posedge core_clk);
      link_in <= rows[i][11:6];
      repeat (10) @(posedge core_clk);
      watch(80);
      check("link colours", {4'h0, link_seen}, {4'h0, rows[i][5:2]});
      check("link rate", rate_of(link_chg), {6'h00, rows[i][1:0]});
    end
    @(posedge core_clk);
    trigger_mode <= 1'b1;
    for (int p = 5; p < 20; p += 12)
    begin
      trig_period = p;
      repeat (40) @(posedge core_clk);
      watch(96);
      check("trigger colours", {4'h0, ptr_seen}, 8'h05);
      check("trigger blinks", ptr_chg, 8'h08);
    end
    @(posedge core_clk);
    trigger_mode <= 1'b0;
    repeat (50) @(posedge core_clk);
    watch(40);
    check("no trigger mode", {4'h0, ptr_seen}, 8'h04);
    trig_period = 0;
    // Triggers stopped in trigger mode: blink ends once the hold runs out
    @(posedge core_clk);
    trigger_mode <= 1'b1;
    repeat (2100) @(posedge core_clk);
    watch(40);
    check("trigger stopped", {4'h0, ptr_seen}, 8'h04);
    @(posedge core_clk);
    trigger_mode <= 1'b0;
    for (int c = 1; c >= 0; c--)
    begin
      @(posedge core_clk);
      link_in <= {1'b0, c[0], 4'h8};
      repeat (20) @(posedge core_clk);
      link_detecting <= 1'b1;
      @(posedge core_clk);
      link_detecting <= 1'b0;
      repeat (6) @(posedge core_clk);
      watch(12);
      check("detect colours", {4'h0, link_seen}, c[0] ? 8'h0c : 8'h09);
      repeat (40) @(posedge core_clk);
      #1 check("after detect", {6'h00, link_lamp}, 8'h02);
    end
    report_and_stop();
  end
endmodule
bind csled_driver csled_driver_asserts chk (.core_clk, .sys_rst, .init_done, .trigger_mode,
  .link_powering, .link_cable_power, .link_detecting, .link_up, .link_waiting,
  .link_streaming, .link_testing, .power_trigger_indicator, .link_indicator);
`default_nettype wire
